//--- common/adc_pm_defs.svh
`ifndef ADC_PM_DEFS_SVH
`define ADC_PM_DEFS_SVH
// block clock period in nanoseconds (10 MHz)
`define CLK_PERIOD_NS 100
// short power-up interval, ns
`define PWRUP_SHORT_NS 1500
// long power-up interval (internal reference start), ns
`define PWRUP_LONG_NS 30000
// conversion time, ns
`define CONV_TIME_NS 2300
// settling time after a conversion, ns
`define SETTLE_NS 100
// cycle counts; least times round up
`define PWRUP_SHORT_CYC \
    ((`PWRUP_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWRUP_LONG_CYC \
    ((`PWRUP_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYC \
    ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// result width and code count
`define RESULT_W 10
`define CODE_COUNT 1024
// power-down control encodings {hi, lo}
`define PD_FULL_UP 2'h3
`define PD_FULL_DOWN 2'h0
`define PD_PARTIAL 2'h1
`define PD_AUTO_FULL 2'h2
`endif

//--- common/adc_pm_pkg.sv
package adc_pm_pkg;
    // control bits written by the host
    typedef struct packed {
        logic power_down_ctl_hi;
        logic power_down_ctl_lo;
        logic external_reference_select;
    } ctl_s;
    // power status outputs
    typedef struct packed {
        logic core_powered;
        logic reference_powered;
        logic reference_amp_on;
        logic ready;
    } pwr_s;
    // sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        ST_OFF = 3'h0,
        ST_PWRUP = 3'h1,
        ST_IDLE = 3'h3,
        ST_CONV = 3'h2,
        ST_AUTO_DOWN = 3'h6
    } state_e;
endpackage

//--- logic/adc_power_mode_control.sv
`timescale 1ns/1ps
`include "adc_pm_defs.svh"

// Notes on behaviour
// - acquisition runs from conversion end to start fall
// - bit 0 picks external reference, amp off
// - results are unsigned straight binary, 1024 codes
// - 11 always powered, 00 always powered down
// - 01 with start low: partial down, ref kept
// - 10 with start low: full down incl reference
// - start level sampled at each conversion end
// - rising start edge wakes from auto power-down
// - after supply: powered down until host writes 11
// - writing 00 then 11 resets the device
// - 1.5 us wake with external ref or partial
// - 30 us long wake, 1.5 us after brief down
// - partial down keeps reference up after startup
// - conversion lasts 2.3 us then result is latched
// - early start fall waits for power-up end
module adc_power_mode_control #(
    parameter int PWRUP_SHORT_CYC = `PWRUP_SHORT_CYC,
    parameter int PWRUP_LONG_CYC = `PWRUP_LONG_CYC,
    parameter int CONV_CYC = `CONV_CYC,
    parameter int LONG_DOWN_CYC = 1000
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic conversion_start_n_in,
    input wire logic ctl_write_in,
    input wire adc_pm_pkg::ctl_s ctl_in,
    input wire logic [`RESULT_W-1:0] sar_code_in,
    output adc_pm_pkg::pwr_s pwr_out,
    output logic acquiring_out,
    output logic converting_out,
    output logic result_valid_out,
    output logic [`RESULT_W-1:0] result_out,
    output logic internal_reset_out
);
    // counter wide enough for every interval
    localparam int CNT_W = 16;

    // refuse zero counts and long, down or conversion counts the counter cannot hold
    initial begin
        if (PWRUP_SHORT_CYC < 1 || PWRUP_LONG_CYC < 1 || CONV_CYC < 1 ||
            LONG_DOWN_CYC < 1 || PWRUP_LONG_CYC >= (1 << CNT_W) ||
            LONG_DOWN_CYC >= (1 << CNT_W) ||
            CONV_CYC >= (1 << CNT_W)) begin
            $error("adc_power_mode_control: bad counts");
        end
    end

    // pin synchroniser and edge history
    logic cs_meta_ff;
    logic cs_sync_ff;
    logic cs_prev_ff;
    // control state
    adc_pm_pkg::ctl_s ctl_ff;
    logic saw_zero_ff; // 00 written, waiting for 11
    logic ref_warm_ff; // reference and cap are charged
    logic irst_ff;
    adc_pm_pkg::state_e state_ff;
    adc_pm_pkg::state_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] down_cnt_ff; // length of full power-down
    logic pend_ff; // start fell during power-up
    logic nxt_pend;
    logic [`RESULT_W-1:0] result_ff;
    logic valid_ff;

    // narrow an int terminal count to the counter width
    function automatic logic [CNT_W-1:0] term(input int n);
        term = CNT_W'(n - 1);
    endfunction

    // decoded pin events
    wire cs_fall = cs_prev_ff & ~cs_sync_ff;
    wire cs_rise = ~cs_prev_ff & cs_sync_ff;
    // decoded control bits
    wire [1:0] pd = {ctl_ff.power_down_ctl_hi, ctl_ff.power_down_ctl_lo};
    wire [1:0] pd_new = {ctl_in.power_down_ctl_hi, ctl_in.power_down_ctl_lo};
    wire wr_zero = ctl_write_in && (pd_new == `PD_FULL_DOWN);
    wire wr_reset = ctl_write_in && (pd_new == `PD_FULL_UP) && saw_zero_ff;
    wire forced_down = (pd == `PD_FULL_DOWN);
    wire auto_mode = (pd == `PD_PARTIAL) || (pd == `PD_AUTO_FULL);
    wire cnt_done = (cnt_ff == '0);
    wire conv_end = (state_ff == adc_pm_pkg::ST_CONV) && cnt_done;
    wire ref_kept = (pd == `PD_PARTIAL);
    // long wake unless external ref or reference already warm
    wire long_wake = !ctl_ff.external_reference_select && !ref_warm_ff;
    wire [CNT_W-1:0] wake_cnt = long_wake ? term(PWRUP_LONG_CYC)
                                          : term(PWRUP_SHORT_CYC);

    // two-flop synchroniser on the start pin
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end else begin
            cs_meta_ff <= conversion_start_n_in;
            cs_sync_ff <= cs_meta_ff;
            cs_prev_ff <= cs_sync_ff;
        end
    end

    // control register, reset-sequence tracking
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl_ff <= '0;
            saw_zero_ff <= 1'b0;
            irst_ff <= 1'b0;
        end else begin
            irst_ff <= wr_reset;
            if (ctl_write_in) begin
                ctl_ff <= ctl_in;
            end
            if (wr_zero) begin
                saw_zero_ff <= 1'b1;
            end else if (ctl_write_in) begin
                saw_zero_ff <= 1'b0;
            end
        end
    end

    // sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        nxt_pend = pend_ff;
        case (state_ff)
            adc_pm_pkg::ST_OFF: begin
                // stay low-current until told to power up
                if (!forced_down && !auto_mode) begin
                    nxt_state = adc_pm_pkg::ST_PWRUP;
                    nxt_cnt = wake_cnt;
                    nxt_pend = 1'b0;
                end
            end
            adc_pm_pkg::ST_PWRUP: begin
                if (cs_fall) begin
                    nxt_pend = 1'b1;
                end
                if (cnt_done) begin
                    if (pend_ff || cs_fall) begin
                        nxt_state = adc_pm_pkg::ST_CONV;
                        nxt_cnt = term(CONV_CYC);
                    end else begin
                        nxt_state = adc_pm_pkg::ST_IDLE;
                    end
                    nxt_pend = 1'b0;
                end
            end
            adc_pm_pkg::ST_IDLE: begin
                // acquisition ends at the start fall
                if (cs_fall) begin
                    nxt_state = adc_pm_pkg::ST_CONV;
                    nxt_cnt = term(CONV_CYC);
                end
            end
            adc_pm_pkg::ST_CONV: begin
                if (cnt_done) begin
                    // sampled start level picks the next state
                    if (auto_mode && !cs_sync_ff) begin
                        nxt_state = adc_pm_pkg::ST_AUTO_DOWN;
                    end else begin
                        nxt_state = adc_pm_pkg::ST_IDLE;
                    end
                end
            end
            adc_pm_pkg::ST_AUTO_DOWN: begin
                if (cs_rise) begin
                    nxt_state = adc_pm_pkg::ST_PWRUP;
                    nxt_cnt = wake_cnt;
                    nxt_pend = 1'b0;
                end
            end
            default: begin
                nxt_state = adc_pm_pkg::ST_OFF;
                nxt_cnt = '0;
                nxt_pend = 1'b0;
            end
        endcase
        // fixed power-down bits override, reset sequence restarts
        if (forced_down || irst_ff) begin
            nxt_state = adc_pm_pkg::ST_OFF;
            nxt_pend = 1'b0;
        end
    end

    // sequencer registers
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff <= adc_pm_pkg::ST_OFF;
            cnt_ff <= '0;
            pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pend_ff <= nxt_pend;
        end
    end

    // reference warmth: lost on reset, on 00, or on long full power-down
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_warm_ff <= 1'b0;
            down_cnt_ff <= '0;
        end else begin
            if (irst_ff || forced_down) begin
                ref_warm_ff <= 1'b0;
                down_cnt_ff <= '0;
            end else if (state_ff == adc_pm_pkg::ST_PWRUP && cnt_done) begin
                ref_warm_ff <= 1'b1;
                down_cnt_ff <= '0;
            end else if (state_ff == adc_pm_pkg::ST_AUTO_DOWN && !ref_kept) begin
                if (down_cnt_ff == term(LONG_DOWN_CYC)) begin
                    ref_warm_ff <= 1'b0;
                end else begin
                    down_cnt_ff <= down_cnt_ff + 1'b1;
                end
            end
        end
    end

    // result latch at conversion end, straight binary
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            result_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= conv_end;
            if (conv_end) begin
                result_ff <= sar_code_in;
            end
        end
    end

    // status outputs
    wire core_on = (state_ff == adc_pm_pkg::ST_PWRUP) ||
                   (state_ff == adc_pm_pkg::ST_IDLE) ||
                   (state_ff == adc_pm_pkg::ST_CONV);
    wire ref_on = core_on ||
                  (state_ff == adc_pm_pkg::ST_AUTO_DOWN && ref_kept);
    assign pwr_out.core_powered = core_on;
    assign pwr_out.reference_powered = ref_on;
    assign pwr_out.reference_amp_on = ref_on &&
                                      !ctl_ff.external_reference_select;
    assign pwr_out.ready = (state_ff == adc_pm_pkg::ST_IDLE);
    assign acquiring_out = (state_ff == adc_pm_pkg::ST_IDLE);
    assign converting_out = (state_ff == adc_pm_pkg::ST_CONV);
    assign result_valid_out = valid_ff;
    assign result_out = result_ff;
    assign internal_reset_out = irst_ff;
endmodule

//--- test/adc_host_model.sv
`timescale 1ns/1ps
// host side: drives the active-low conversion start pin
module adc_host_model (
    input wire logic clk_sys_in,
    input wire logic go_in, // request a start pulse
    input wire logic hold_in, // keep pin low past conversion end
    input wire logic [7:0] low_cyc_in, // pulse length in cycles
    input wire logic converting_in, // device converting
    output logic conversion_start_n_out
);
    logic [7:0] cnt_ff = 8'h00; // low cycles left
    logic [1:0] gap_ff = 2'h0; // settle cycles left
    logic conv_q = 1'b0; // converting, one cycle back
    initial conversion_start_n_out = 1'b1;
    // pulse length and spacing after each conversion end
    always @(posedge clk_sys_in) begin
        conv_q <= converting_in;
        if (conv_q && !converting_in) begin
            gap_ff <= 2'h2;
        end else if (gap_ff != 2'h0) begin
            gap_ff <= gap_ff - 2'h1;
        end
        if (go_in && cnt_ff == 8'h00 && gap_ff == 2'h0) begin
            cnt_ff <= low_cyc_in;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
        end
    end
    // pin moves away from the sampling edge
    always @(negedge clk_sys_in) begin
        conversion_start_n_out <= !(cnt_ff != 8'h00 || hold_in);
    end
endmodule

//--- test/adc_pm_monitor.sv
`timescale 1ns/1ps
`include "adc_pm_defs.svh"
// checks power modes and conversion timing at the ports
module adc_pm_monitor #(
    parameter int CONV_CYC = 23
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic conversion_start_n_in,
    input wire logic ctl_write_in,
    input wire adc_pm_pkg::ctl_s ctl_in,
    input wire logic [`RESULT_W-1:0] sar_code_in,
    input wire adc_pm_pkg::pwr_s pwr_out,
    input wire logic acquiring_out,
    input wire logic converting_out,
    input wire logic result_valid_out,
    input wire logic [`RESULT_W-1:0] result_out,
    input wire logic internal_reset_out
);
    logic [1:0] mode_ff; // last power-down bits
    logic ext_ff; // last reference select
    logic [7:0] cnt_ff; // cycles spent converting
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // shadow of control bits and conversion length
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mode_ff <= 2'h0;
            ext_ff <= 1'b0;
            cnt_ff <= 8'h00;
        end else begin
            if (ctl_write_in) begin
                mode_ff <= {ctl_in.power_down_ctl_hi,
                    ctl_in.power_down_ctl_lo};
                ext_ff <= ctl_in.external_reference_select;
            end
            cnt_ff <= converting_out ? cnt_ff + 8'h01 : 8'h00;
        end
    end
    a_off_mode_down: assert property (
        mode_ff == `PD_FULL_DOWN && $past(mode_ff) == `PD_FULL_DOWN
        |-> !pwr_out.core_powered)
        else $error("powered while off");
    a_up_mode_stays: assert property (
        mode_ff == `PD_FULL_UP && pwr_out.ready && !ctl_write_in
        |=> pwr_out.core_powered) else $error("full-up mode dropped");
    a_ext_amp_off: assert property (
        pwr_out.core_powered && ext_ff |-> !pwr_out.reference_amp_on)
        else $error("amplifier on with external reference");
    a_partial_ref_kept: assert property (
        mode_ff == `PD_PARTIAL && !ctl_write_in
        && $past(pwr_out.reference_powered)
        |-> pwr_out.reference_powered) else $error("partial lost ref");
    a_conv_bound: assert property (
        converting_out |-> cnt_ff < CONV_CYC)
        else $error("conversion too long");
    a_conv_end: assert property (
        $fell(converting_out) |-> cnt_ff == CONV_CYC
        ##[0:1] result_valid_out) else $error("bad conversion end");
    a_valid_pulse: assert property (
        result_valid_out |=> !result_valid_out)
        else $error("result pulse too long");
    a_start_conv: assert property (
        acquiring_out && $fell(conversion_start_n_in)
        |-> ##[1:5] converting_out) else $error("start fall ignored");
    a_reset_pulse: assert property (
        internal_reset_out |=> !internal_reset_out)
        else $error("reset pulse too long");
    a_partial_wake: assert property (
        mode_ff == `PD_PARTIAL && pwr_out.reference_powered
        && !pwr_out.core_powered && $rose(conversion_start_n_in)
        |-> ##[1:30] pwr_out.ready) else $error("slow partial wake");
    c_conv: cover property ($fell(converting_out));
    c_reset: cover property (internal_reset_out);
    c_full_auto: cover property (mode_ff == `PD_AUTO_FULL
        && !pwr_out.core_powered);
endmodule

bind adc_power_mode_control adc_pm_monitor #(.CONV_CYC(CONV_CYC)) mon (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .conversion_start_n_in(conversion_start_n_in),
    .ctl_write_in(ctl_write_in), .ctl_in(ctl_in),
    .sar_code_in(sar_code_in), .pwr_out(pwr_out),
    .acquiring_out(acquiring_out), .converting_out(converting_out),
    .result_valid_out(result_valid_out), .result_out(result_out),
    .internal_reset_out(internal_reset_out));

//--- test/test_adc_power_mode_control.sv
`timescale 1ns/1ps
`include "adc_pm_defs.svh"
// control writes and host pulses; results scored from a queue
module test_adc_power_mode_control;
    localparam int LONG = 20; // shortened long wake
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic ctl_write_in = 1'b0;
    adc_pm_pkg::ctl_s ctl_in = 3'h0;
    logic [`RESULT_W-1:0] sar_code_in = 10'h000;
    logic go = 1'b0; // host pulse request
    logic hold = 1'b0; // host keeps pin low
    logic start_n; // conversion start pin
    adc_pm_pkg::pwr_s pwr_out;
    logic acquiring_out, converting_out, result_valid_out;
    logic internal_reset_out;
    logic [`RESULT_W-1:0] result_out;
    logic [`RESULT_W-1:0] exp_q[$]; // codes awaiting results
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    // free-running block clock
    initial forever #50 clk_sys_in = ~clk_sys_in;
    adc_power_mode_control #(.PWRUP_LONG_CYC(LONG), .LONG_DOWN_CYC(10))
    dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .conversion_start_n_in(start_n), .ctl_write_in(ctl_write_in),
        .ctl_in(ctl_in), .sar_code_in(sar_code_in), .pwr_out(pwr_out),
        .acquiring_out(acquiring_out), .converting_out(converting_out),
        .result_valid_out(result_valid_out), .result_out(result_out),
        .internal_reset_out(internal_reset_out));
    adc_host_model host (.clk_sys_in(clk_sys_in), .go_in(go),
        .hold_in(hold), .low_cyc_in(8'h03),
        .converting_in(converting_out), .conversion_start_n_out(start_n));
    task check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one control write strobe
    task write(input logic [2:0] v);
        @(negedge clk_sys_in);
        ctl_in = v;
        ctl_write_in = 1'b1;
        @(negedge clk_sys_in);
        ctl_write_in = 1'b0;
    endtask
    task wait_ready;
        n = 0;
        while (pwr_out.ready !== 1'b1 && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask
    task wait_conv(input logic v);
        while (converting_out !== v && n < 400) begin
            @(negedge clk_sys_in);
            n++;
        end
    endtask
    // one conversion with a random code, pin held low if h
    task conv(input logic h);
        @(negedge clk_sys_in);
        sar_code_in = `RESULT_W'($urandom);
        exp_q.push_back(sar_code_in);
        go = 1'b1;
        hold = h;
        n = 0;
        while (start_n !== 1'b0 && n < 50) begin
            @(negedge clk_sys_in);
            n++;
        end
        go = 1'b0;
        wait_conv(1'b1);
        wait_conv(1'b0);
        repeat (3) @(negedge clk_sys_in);
    endtask
    // scoreboard: each result against the oldest code
    always @(negedge clk_sys_in) begin
        if (result_valid_out === 1'b1) begin
            if (exp_q.size() == 0) check("extra result", 1, 0);
            else check("result", result_out, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    initial begin
        void'($urandom(34));
        repeat (16) @(negedge clk_sys_in);
        rst_b_in = 1'b1;
        go = 1'b1;
        repeat (12) @(negedge clk_sys_in);
        go = 1'b0;
        // let the last ignored pulse end before powering up
        repeat (6) @(negedge clk_sys_in);
        check("off power", pwr_out.core_powered, 0);
        check("off conv", converting_out, 0);
        write(3'h6);
        wait_ready;
        check("long wake", n >= LONG - 2, 1);
        check("amp on", pwr_out.reference_amp_on, 1);
        repeat (4) conv(1'b0);
        check("mode1 up", pwr_out.ready, 1);
        write(3'h2);
        conv(1'b1);
        check("partial core", pwr_out.core_powered, 0);
        check("partial ref", pwr_out.reference_powered, 1);
        hold = 1'b0;
        wait_ready;
        check("partial wake", n <= `PWRUP_SHORT_CYC + 6, 1);
        write(3'h5);
        conv(1'b1);
        check("full core", pwr_out.core_powered, 0);
        check("full ref", pwr_out.reference_powered, 0);
        hold = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        conv(1'b0);
        check("ext amp", pwr_out.reference_amp_on, 0);
        check("full high", pwr_out.ready, 1);
        write(3'h0);
        // state drops one edge after the control bits land
        @(negedge clk_sys_in);
        check("off write", pwr_out.core_powered, 0);
        write(3'h6);
        n = 0;
        while (internal_reset_out !== 1'b1 && n < 4) begin
            @(negedge clk_sys_in);
            n++;
        end
        check("int reset", internal_reset_out, 1);
        wait_ready;
        conv(1'b0);
        check("pending", exp_q.size(), 0);
        report_and_stop;
    end
endmodule
